// file: hw/addr_mode_eff_addr_timing.sv
// Operation
// - Long relative: sign-extend 16-bit offset, add to next PC; long branch loads it.
// - Push relative address pushes the long relative sum; PC stays unchanged by it.
// - Short branch adds signed byte to next PC only when condition true.
// - Relative computations change only the 16-bit PC; program bank never changes.
// - Stack accesses and interrupt vector fetches always use bank zero.
// - Stack relative: address is stack pointer plus unsigned byte, bank forced zero.
// - Stack relative indirect: pointer in bank zero, data bank high, plus Y.
// - Absolute family cycles 4,4,4,5,5,5,6; lengths 3, long forms 4.
// - Direct family cycles 3,4,4,5,5,6,6,6; all two bytes.
// - Accumulator/implied 2/1, immediate 2/2, block 7/3, short 2/2, long 3/3.
// - Stack 3-8 cycles 1-4 bytes; stack relative 4/2; indirect form 7/2.
// - Marked indexed modes add a cycle when the index crosses a page.
// - A taken relative branch adds one cycle.
// - Direct family adds a cycle when direct register low byte is nonzero.
// - Read-modify-write adds 2 cycles in 8-bit, 3 in 16-bit accumulator width.
//
// Purpose: Effective address and cycle/length calculation for one instruction step
// Assumes: Sequencer presents operands with calc_i; pointer fetch data via ptr_i
// Notes: Results register one cycle after calc_i with clk_en_i high
`default_nettype none
module addr_mode_eff_addr_timing
    import eff_addr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic calc_i,
    input wire logic [4:0] mode_i,
    input wire logic long_op_i,
    input wire logic branch_cond_i,
    input wire logic rmw_i,
    input wire logic stack_access_i,
    input wire logic vector_fetch_i,
    input wire logic [15:0] vector_addr_i,
    input wire logic [7:0] operand_lo_i,
    input wire logic [7:0] operand_hi_i,
    input wire logic [7:0] operand_bank_i,
    input wire logic [15:0] pc_next_i,
    input wire logic [15:0] stack_ptr_i,
    input wire logic [15:0] x_index_i,
    input wire logic [15:0] y_index_i,
    input wire logic [15:0] direct_reg_i,
    input wire logic [7:0] program_bank_reg_i,
    input wire logic [7:0] data_bank_reg_i,
    input wire logic [15:0] ptr_i,
    input wire logic acc_wide_i,
    input wire logic idx_wide_i,
    input wire logic [3:0] stack_cycles_i,
    input wire logic [2:0] stack_len_i,
    output logic [23:0] eff_addr_o,
    output logic [23:0] ptr_addr_o,
    output logic [15:0] pc_load_o,
    output logic pc_load_en_o,
    output logic [15:0] push_value_o,
    output logic push_en_o,
    output logic [7:0] program_bank_o,
    output logic [3:0] cycles_o,
    output logic [2:0] length_o,
    output logic valid_o
);
    // =====================================================
    // Helpers
    function automatic logic [15:0] sext8(input logic [7:0] v);
        sext8 = {{8{v[7]}}, v};
    endfunction : sext8

    function automatic logic [23:0] in_bank(input logic [7:0] bank, input logic [15:0] lo);
        in_bank = {bank, lo};
    endfunction : in_bank

    // =====================================================
    // Combinational address path
    addr_mode_e mode;
    logic [15:0] operand16;
    logic [15:0] rel_sum;
    logic [15:0] sp_sum;
    logic [23:0] add_a;
    logic [23:0] add_b;
    logic [23:0] add_sum;
    logic add_cross;
    logic [3:0] base_cycles;
    logic [2:0] base_len;
    logic [23:0] eff_next;
    logic [23:0] ptr_next;
    logic pc_en_next;
    logic push_en_next;
    logic [3:0] cycles_next;
    logic [2:0] len_next;
    logic indexed_mark;
    logic wide_mark;
    logic direct_family;

    assign mode = addr_mode_e'(mode_i);
    assign operand16 = {operand_hi_i, operand_lo_i};

    assign rel_sum = (mode == M_REL_LONG) ? pc_next_i + operand16 : pc_next_i + sext8(operand_lo_i);

    // unsigned offset, wraps within bank zero
    assign sp_sum = stack_ptr_i + {8'h00, operand_lo_i};

    always_comb begin
        add_a = in_bank(data_bank_reg_i, operand16);
        add_b = 24'h000000;
        case (mode)
            M_ABS_X: begin add_a = in_bank(data_bank_reg_i, operand16); add_b = {8'h00, x_index_i}; end
            M_ABS_Y: begin add_a = in_bank(data_bank_reg_i, operand16); add_b = {8'h00, y_index_i}; end
            M_ABS_LONG_X: begin add_a = {operand_bank_i, operand16}; add_b = {8'h00, x_index_i}; end
            // base from pointer and data bank, plus Y
            M_DIR_IND_Y, M_STACK_REL_IND_Y: begin
                add_a = in_bank(data_bank_reg_i, ptr_i);
                add_b = {8'h00, y_index_i};
            end
            default: begin add_a = in_bank(data_bank_reg_i, operand16); add_b = 24'h000000; end
        endcase
    end

    addr_adder u_adder (
        .a_i(add_a),
        .b_i(add_b),
        .sum_o(add_sum),
        .page_cross_o(add_cross)
    );

    mode_timing u_timing (
        .mode_i(mode_i),
        .stack_cycles_i(stack_cycles_i),
        .stack_len_i(stack_len_i),
        .base_cycles_o(base_cycles),
        .base_len_o(base_len)
    );

    always_comb begin
        eff_next = add_sum;
        ptr_next = in_bank(ZERO_BANK, 16'h0000);
        pc_en_next = 1'b0;
        push_en_next = 1'b0;
        case (mode)
            M_ABS, M_ABS_X, M_ABS_Y, M_ABS_LONG_X, M_DIR_IND_Y: eff_next = add_sum;
            M_ABS_LONG: eff_next = {operand_bank_i, operand16};
            M_DIR, M_DIR_X, M_DIR_Y: eff_next = in_bank(ZERO_BANK,
                direct_reg_i + {8'h00, operand_lo_i} +
                ((mode == M_DIR_X) ? x_index_i : (mode == M_DIR_Y) ? y_index_i : 16'h0000));
            M_REL: begin
                eff_next = in_bank(program_bank_reg_i, rel_sum);
                pc_en_next = branch_cond_i;
            end
            M_REL_LONG: begin
                eff_next = in_bank(program_bank_reg_i, rel_sum);
                // branch loads PC, push leaves it
                pc_en_next = (long_op_i == LONG_OP_BRANCH);
                push_en_next = (long_op_i == LONG_OP_PUSH);
            end
            M_STACK_REL: eff_next = in_bank(ZERO_BANK, sp_sum);
            M_STACK_REL_IND_Y: begin
                ptr_next = in_bank(ZERO_BANK, sp_sum);
                eff_next = add_sum;
            end
            default: eff_next = add_sum;
        endcase
        // stack and vector accesses in bank zero
        if (vector_fetch_i) begin
            eff_next = in_bank(ZERO_BANK, vector_addr_i);
        end else if (stack_access_i) begin
            eff_next = in_bank(ZERO_BANK, stack_ptr_i);
        end
    end

    // =====================================================
    // Cycle extras
    assign indexed_mark = (mode == M_ABS_X) || (mode == M_ABS_Y) || (mode == M_DIR_IND_Y);
    assign direct_family = (mode == M_DIR) || (mode == M_DIR_X) || (mode == M_DIR_Y) ||
                           (mode == M_DIR_IND) || (mode == M_DIR_IND_Y) || (mode == M_DIR_IDX_IND) ||
                           (mode == M_DIR_IND_LONG) || (mode == M_DIR_IND_LONG_Y);
    // Width-sensitive modes: all but accumulator, implied, block, both relative, stack and the two absolute indirect modes
    assign wide_mark = !((mode == M_ACC) || (mode == M_IMPL) || (mode == M_BLOCK) || (mode == M_REL) ||
                         (mode == M_REL_LONG) || (mode == M_STACK) || (mode == M_ABS_IND) ||
                         (mode == M_ABS_IDX_IND));

    always_comb begin
        cycles_next = base_cycles;
        len_next = base_len;
        if (indexed_mark && add_cross) begin
            cycles_next = cycles_next + ADD_ONE;
        end
        if (mode == M_REL && branch_cond_i) begin
            cycles_next = cycles_next + ADD_ONE;
        end
        if (mode == M_REL_LONG && long_op_i == LONG_OP_BRANCH) begin
            cycles_next = cycles_next + ADD_ONE;
        end
        if (wide_mark && (acc_wide_i || idx_wide_i)) begin
            cycles_next = cycles_next + ADD_ONE;
            if (mode == M_IMM) begin
                len_next = len_next + LEN_1;
            end
        end
        if (direct_family && direct_reg_i[7:0] != PAGE_ZERO_LOW) begin
            cycles_next = cycles_next + ADD_ONE;
        end
        if (rmw_i) begin
            cycles_next = cycles_next + (acc_wide_i ? RMW_ADD_WIDE : RMW_ADD_NARROW);
        end
    end

    // =====================================================
    // Registered results
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            eff_addr_o <= 24'h000000;
            ptr_addr_o <= 24'h000000;
            pc_load_o <= 16'h0000;
            pc_load_en_o <= 1'b0;
            push_value_o <= 16'h0000;
            push_en_o <= 1'b0;
            cycles_o <= 4'h0;
            length_o <= 3'h0;
            valid_o <= 1'b0;
        end else if (clk_en_i) begin
            valid_o <= calc_i;
            pc_load_en_o <= calc_i & pc_en_next;
            push_en_o <= calc_i & push_en_next;
            if (calc_i) begin
                eff_addr_o <= eff_next;
                ptr_addr_o <= ptr_next;
                pc_load_o <= rel_sum;
                push_value_o <= rel_sum;
                cycles_o <= cycles_next;
                length_o <= len_next;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            program_bank_o <= 8'h00;
        end else if (clk_en_i) begin
            program_bank_o <= program_bank_reg_i;
        end
    end

    // =====================================================
    // Checks
    sequence s_calc_long_push;
        calc_i && clk_en_i && mode == M_REL_LONG && long_op_i == LONG_OP_PUSH && !stack_access_i;
    endsequence

    a_long_branch_target: assert property (@(posedge clk_i) disable iff (rst_i)
        calc_i && clk_en_i && mode == M_REL_LONG && long_op_i == LONG_OP_BRANCH
        |=> pc_load_en_o && pc_load_o == $past(pc_next_i) + {$past(operand_hi_i), $past(operand_lo_i)})
        else $error("long branch target wrong");
    a_push_no_load: assert property (@(posedge clk_i) disable iff (rst_i)
        s_calc_long_push |=> push_en_o && !pc_load_en_o) else $error("push relative loaded pc");
    a_short_branch_cond: assert property (@(posedge clk_i) disable iff (rst_i)
        calc_i && clk_en_i && mode == M_REL |=> pc_load_en_o == $past(branch_cond_i))
        else $error("short branch condition ignored");
    a_rel_bank_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        calc_i && clk_en_i && (mode == M_REL || mode == M_REL_LONG) && !stack_access_i && !vector_fetch_i
        |=> eff_addr_o[23:16] == $past(program_bank_reg_i)) else $error("relative changed bank");
    a_stack_bank_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        calc_i && clk_en_i && (stack_access_i || vector_fetch_i) |=> eff_addr_o[23:16] == 8'h00)
        else $error("stack access not in bank zero");
    a_stack_rel_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        calc_i && clk_en_i && mode == M_STACK_REL && !stack_access_i && !vector_fetch_i
        |=> eff_addr_o == {8'h00, 16'($past(stack_ptr_i) + $past(operand_lo_i))})
        else $error("stack relative address wrong");
    a_srii_pointer: assert property (@(posedge clk_i) disable iff (rst_i)
        calc_i && clk_en_i && mode == M_STACK_REL_IND_Y |=> ptr_addr_o[23:16] == 8'h00)
        else $error("indirect pointer not in bank zero");
    a_rmw_extra: assert property (@(posedge clk_i) disable iff (rst_i)
        calc_i && clk_en_i && mode == M_ABS && rmw_i && !acc_wide_i && !idx_wide_i
        |=> cycles_o == 4'h6) else $error("read-modify-write cycles wrong");
    a_direct_unaligned: assert property (@(posedge clk_i) disable iff (rst_i)
        calc_i && clk_en_i && mode == M_DIR && !rmw_i && !acc_wide_i && !idx_wide_i && direct_reg_i[7:0] != 8'h00
        |=> cycles_o == 4'h4) else $error("direct unaligned cycle missing");

    sequence s_calc_taken_short;
        calc_i && clk_en_i && mode == M_REL && branch_cond_i && !rmw_i;
    endsequence

    a_taken_branch_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        s_calc_taken_short |=> cycles_o == 4'h3) else $error("taken branch cycle missing");
    a_page_cross_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        calc_i && clk_en_i && mode == M_ABS_X && !rmw_i && !acc_wide_i && !idx_wide_i &&
        ({1'b0, operand_lo_i} + {1'b0, x_index_i[7:0]}) > 9'h0FF |=> cycles_o == 4'h5)
        else $error("page cross cycle missing");
    a_wide_imm_len: assert property (@(posedge clk_i) disable iff (rst_i)
        calc_i && clk_en_i && mode == M_IMM && !rmw_i && (acc_wide_i || idx_wide_i)
        |=> cycles_o == 4'h3 && length_o == 3'h3) else $error("wide immediate timing wrong");
    a_srii_eff_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        calc_i && clk_en_i && mode == M_STACK_REL_IND_Y && !stack_access_i && !vector_fetch_i
        |=> eff_addr_o == {$past(data_bank_reg_i), $past(ptr_i)} + {8'h00, $past(y_index_i)})
        else $error("indirect indexed address wrong");
endmodule : addr_mode_eff_addr_timing
`default_nettype wire

// file: hw/eff_addr_pkg.sv
// Purpose: Shared constants for the effective address and timing block
// Assumes: 16-bit program counter and stack pointer, 24-bit address bus
// Notes: Mode codes are shared by the top module, mode_timing and the bench; long relative codes by the top module and the bench
`default_nettype none
package eff_addr_pkg;
    // =====================================================
    // Widths
    localparam int ADDR_W = 24;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [7:0] ZERO_BANK = 8'h00;
    localparam logic [7:0] PAGE_ZERO_LOW = 8'h00;

    // =====================================================
    // Addressing modes
    typedef enum logic [4:0] {
        M_ABS = 5'h00, M_ABS_IDX_IND = 5'h01, M_ABS_IND = 5'h02, M_ABS_LONG = 5'h03,
        M_ABS_LONG_X = 5'h04, M_ABS_X = 5'h05, M_ABS_Y = 5'h06, M_ACC = 5'h07,
        M_BLOCK = 5'h08, M_DIR = 5'h09, M_DIR_IDX_IND = 5'h0A, M_DIR_IND = 5'h0B,
        M_DIR_IND_Y = 5'h0C, M_DIR_IND_LONG_Y = 5'h0D, M_DIR_IND_LONG = 5'h0E,
        M_DIR_X = 5'h0F, M_DIR_Y = 5'h10, M_IMM = 5'h11, M_IMPL = 5'h12,
        M_REL = 5'h13, M_REL_LONG = 5'h14, M_STACK = 5'h15, M_STACK_REL = 5'h16,
        M_STACK_REL_IND_Y = 5'h17
    } addr_mode_e;

    // Long relative use
    localparam logic LONG_OP_BRANCH = 1'b0;
    localparam logic LONG_OP_PUSH = 1'b1;

    // =====================================================
    // Cycle and length figures
    localparam logic [3:0] CYC_2 = 4'h2;
    localparam logic [3:0] CYC_3 = 4'h3;
    localparam logic [3:0] CYC_4 = 4'h4;
    localparam logic [3:0] CYC_5 = 4'h5;
    localparam logic [3:0] CYC_6 = 4'h6;
    localparam logic [3:0] CYC_7 = 4'h7;
    localparam logic [3:0] CYC_STACK_MIN = 4'h3;
    localparam logic [3:0] CYC_STACK_MAX = 4'h8;
    localparam logic [2:0] LEN_1 = 3'h1;
    localparam logic [2:0] LEN_2 = 3'h2;
    localparam logic [2:0] LEN_3 = 3'h3;
    localparam logic [2:0] LEN_4 = 3'h4;
    localparam logic [3:0] ADD_ONE = 4'h1;
    localparam logic [3:0] RMW_ADD_NARROW = 4'h2;
    localparam logic [3:0] RMW_ADD_WIDE = 4'h3;
endpackage : eff_addr_pkg
`default_nettype wire

// file: hw/mode_timing.sv
// Purpose: Base cycle count and instruction length per addressing mode
// Assumes: Stack mode figures come from the sequencer within 3-8 and 1-4
// Notes: Combinational; extras are added by the top module
`default_nettype none
module mode_timing
    import eff_addr_pkg::*;
(
    input wire logic [4:0] mode_i,
    input wire logic [3:0] stack_cycles_i,
    input wire logic [2:0] stack_len_i,
    output logic [3:0] base_cycles_o,
    output logic [2:0] base_len_o
);
    // =====================================================
    // Table
    always_comb begin
        base_cycles_o = CYC_2;
        base_len_o = LEN_1;
        case (addr_mode_e'(mode_i))
            M_ABS, M_ABS_X, M_ABS_Y: begin base_cycles_o = CYC_4; base_len_o = LEN_3; end
            M_ABS_LONG, M_ABS_LONG_X: begin base_cycles_o = CYC_5; base_len_o = LEN_4; end
            M_ABS_IND: begin base_cycles_o = CYC_5; base_len_o = LEN_3; end
            M_ABS_IDX_IND: begin base_cycles_o = CYC_6; base_len_o = LEN_3; end
            M_DIR: begin base_cycles_o = CYC_3; base_len_o = LEN_2; end
            M_DIR_X, M_DIR_Y: begin base_cycles_o = CYC_4; base_len_o = LEN_2; end
            M_DIR_IND, M_DIR_IND_Y: begin base_cycles_o = CYC_5; base_len_o = LEN_2; end
            M_DIR_IDX_IND, M_DIR_IND_LONG, M_DIR_IND_LONG_Y: begin
                base_cycles_o = CYC_6;
                base_len_o = LEN_2;
            end
            M_ACC, M_IMPL: begin base_cycles_o = CYC_2; base_len_o = LEN_1; end
            M_IMM: begin base_cycles_o = CYC_2; base_len_o = LEN_2; end
            M_BLOCK: begin base_cycles_o = CYC_7; base_len_o = LEN_3; end
            M_REL: begin base_cycles_o = CYC_2; base_len_o = LEN_2; end
            M_REL_LONG: begin base_cycles_o = CYC_3; base_len_o = LEN_3; end
            M_STACK: begin
                base_cycles_o = (stack_cycles_i < CYC_STACK_MIN) ? CYC_STACK_MIN :
                                (stack_cycles_i > CYC_STACK_MAX) ? CYC_STACK_MAX : stack_cycles_i;
                base_len_o = (stack_len_i < LEN_1) ? LEN_1 : (stack_len_i > LEN_4) ? LEN_4 : stack_len_i;
            end
            M_STACK_REL: begin base_cycles_o = CYC_4; base_len_o = LEN_2; end
            M_STACK_REL_IND_Y: begin base_cycles_o = CYC_7; base_len_o = LEN_2; end
            default: begin base_cycles_o = CYC_2; base_len_o = LEN_1; end
        endcase
    end
endmodule : mode_timing
`default_nettype wire

// file: hw/addr_adder.sv
// Purpose: Shared 24-bit adder for effective address arithmetic
// Assumes: Operands already aligned by the caller
// Notes: Also reports a carry out of the low byte for page crossing
`default_nettype none
module addr_adder
    import eff_addr_pkg::*;
(
    input wire logic [23:0] a_i,
    input wire logic [23:0] b_i,
    output logic [23:0] sum_o,
    output logic page_cross_o
);
    logic [8:0] low_sum;
    // =====================================================
    // Sum
    assign sum_o = a_i + b_i;
    assign low_sum = {1'b0, a_i[7:0]} + {1'b0, b_i[7:0]};
    // A carry out of the low byte moves the address into the next page
    assign page_cross_o = low_sum[8];
endmodule : addr_adder
`default_nettype wire

// file: bench/mem_model.sv
// Purpose: Memory on the 24-bit address bus that answers pointer reads
// Assumes: A read is held until ready_o is seen high at a rising edge
// Notes: The data word is a fixed pattern of the address, known to the bench
`default_nettype none
module mem_model
#(
    parameter int DELAY = 3,
    parameter logic [15:0] PATTERN = 16'hA5C3
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rd_i,
    input wire logic [23:0] addr_i,
    output logic [15:0] data_o,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // =====================================================
    // Read latency
    logic [3:0] wait_reg;
    logic [15:0] last_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_reg <= 4'h0;
        end else if (!rd_i) begin
            wait_reg <= 4'h0;
        end else if (wait_reg != 4'(DELAY)) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_reg <= 16'h0000;
        end else begin
            last_reg <= data_o;
        end
    end

    // =====================================================
    // Data lines
    assign ready_o = rd_i && (wait_reg == 4'(DELAY));
    // No answer: lines toggle every cycle so a stale word never passes
    assign data_o = ready_o ? (addr_i[15:0] ^ PATTERN) : ~last_reg;
endmodule : mem_model
`default_nettype wire

// file: bench/addr_mode_eff_addr_timing_tb.sv
// Purpose: Self-checking bench for addr_mode_eff_addr_timing
// Assumes: Inputs change at the falling edge; results one cycle after a request
// Notes: Pointer words for indirect modes come from mem_model
`default_nettype none
module addr_mode_eff_addr_timing_tb
    import eff_addr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // =====================================================
    // Signals and instances
    localparam logic [15:0] MEM_PAT = 16'hA5C3;
    logic clk, rst, en, calc, lop, cond, rmw, sa, vf, aw, iw, rd, rdy, pl_en, ps_en, valid;
    logic [4:0] mode;
    logic [7:0] lo, hi, bk, program_bank_reg, data_bank_reg, pbo;
    logic [15:0] vec, pc, sp, xr, yr, dr, mdata, pcl, psv;
    logic [3:0] scyc, cyc;
    logic [2:0] slen, len;
    logic [23:0] ea, pa;
    int err_total, num_checks;

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    addr_mode_eff_addr_timing u_addr_mode_eff_addr_timing (
        .clk_i(clk), .rst_i(rst), .clk_en_i(en), .calc_i(calc), .mode_i(mode), .long_op_i(lop),
        .branch_cond_i(cond), .rmw_i(rmw), .stack_access_i(sa), .vector_fetch_i(vf), .vector_addr_i(vec),
        .operand_lo_i(lo), .operand_hi_i(hi), .operand_bank_i(bk), .pc_next_i(pc), .stack_ptr_i(sp),
        .x_index_i(xr), .y_index_i(yr), .direct_reg_i(dr), .program_bank_reg_i(program_bank_reg), .data_bank_reg_i(data_bank_reg),
        .ptr_i(mdata), .acc_wide_i(aw), .idx_wide_i(iw), .stack_cycles_i(scyc), .stack_len_i(slen),
        .eff_addr_o(ea), .ptr_addr_o(pa), .pc_load_o(pcl), .pc_load_en_o(pl_en), .push_value_o(psv),
        .push_en_o(ps_en), .program_bank_o(pbo), .cycles_o(cyc), .length_o(len), .valid_o(valid)
    );

    mem_model #(.DELAY(3), .PATTERN(MEM_PAT)) u_mem_model (
        .clk_i(clk), .rst_i(rst), .rd_i(rd), .addr_i(pa), .data_o(mdata), .ready_o(rdy)
    );

    // =====================================================
    // Compare and control tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic hang(input string what);
        err_total++;
        $display("mismatch at %0t: %s timed out", $time, what);
        wrap_up();
    endtask : hang

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_tim(input logic [3:0] c, input logic [2:0] l);
        chk_val({20'h0, cyc}, {20'h0, c});
        chk_val({21'h0, len}, {21'h0, l});
    endtask : chk_tim

    task automatic chk_flags(input logic [1:0] f);
        chk_val({22'h0, pl_en, ps_en}, {22'h0, f});
    endtask : chk_flags

    // One request; pulses are looked at in the cycle they stand
    // Idle edge first so calc is never written twice in one step
    task automatic req(input addr_mode_e m);
        int n;
        n = 0;
        @(negedge clk);
        mode = m;
        calc = 1'b1;
        @(negedge clk);
        calc = 1'b0;
        while (valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (n >= 4) hang("result");
    endtask : req

    // =====================================================
    // Scenarios
    task automatic t_relative();
        pc = 16'h0010;
        lo = 8'h00;
        hi = 8'h80;
        lop = LONG_OP_BRANCH;
        req(M_REL_LONG);
        chk_val({8'h00, pcl}, 24'h008010);
        chk_flags(2'h2);
        chk_tim(4'h4, 3'h3);
        pc = 16'hFFFF;
        hi = 8'h7F;
        lo = 8'hFF;
        lop = LONG_OP_PUSH;
        req(M_REL_LONG);
        chk_val({8'h00, psv}, 24'h007FFE);
        chk_flags(2'h1);
        chk_val({16'h0, pbo}, 24'h00003C);
        pc = 16'hFFF0;
        lo = 8'h7F;
        cond = 1'b1;
        req(M_REL);
        chk_val({8'h00, pcl}, 24'h00006F);
        chk_val(ea, 24'h3C006F);
        chk_flags(2'h2);
        chk_tim(4'h3, 3'h2);
        chk_val({16'h0, pbo}, 24'h00003C);
        cond = 1'b0;
        req(M_REL);
        chk_flags(2'h0);
        chk_tim(4'h2, 3'h2);
        $display("test relative done");
    endtask : t_relative

    task automatic t_stack();
        sa = 1'b1;
        sp = 16'h01FF;
        scyc = 4'h8;
        slen = 3'h4;
        req(M_STACK);
        chk_val({16'h0, ea[23:16]}, 24'h0);
        chk_tim(4'h8, 3'h4);
        scyc = 4'h3;
        slen = 3'h1;
        req(M_STACK);
        chk_tim(4'h3, 3'h1);
        sa = 1'b0;
        vf = 1'b1;
        vec = 16'hFFEE;
        req(M_IMPL);
        chk_val(ea, 24'h00FFEE);
        vf = 1'b0;
        sp = 16'hFFF0;
        lo = 8'hFF;
        req(M_STACK_REL);
        chk_val(ea, 24'h0000EF);
        chk_tim(4'h4, 3'h2);
        $display("test stack done");
    endtask : t_stack

    task automatic t_stack_ind();
        int n;
        n = 0;
        sp = 16'h01F0;
        lo = 8'h20;
        yr = 16'hFFFF;
        req(M_STACK_REL_IND_Y);
        chk_val(pa, 24'h000210);
        chk_tim(4'h7, 3'h2);
        rd = 1'b1;
        while (rdy !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (n >= 10) hang("memory");
        req(M_STACK_REL_IND_Y);
        chk_val(ea, {8'h12, 16'h0210 ^ MEM_PAT} + 24'h00FFFF);
        rd = 1'b0;
        yr = 16'h0000;
        $display("test stack indirect done");
    endtask : t_stack_ind

    task automatic t_table();
        logic [75:0] tc;
        logic [75:0] tl;
        tc = 76'h2244665563724455564;
        tl = 76'h1222222222313344333;
        lo = 8'h10;
        hi = 8'h00;
        // Mode codes 0 to 18 run in table order
        for (int i = 0; i < 19; i++) begin
            req(addr_mode_e'(5'(i)));
            chk_tim(tc[4*i +: 4], tl[4*i +: 3]);
        end
        $display("test table done");
    endtask : t_table

    task automatic t_extras();
        dr = 16'h0001;
        req(M_DIR);
        chk_tim(4'h4, 3'h2);
        dr = 16'h0100;
        req(M_DIR);
        chk_tim(4'h3, 3'h2);
        dr = 16'h0000;
        rmw = 1'b1;
        req(M_DIR);
        chk_tim(4'h5, 3'h2);
        req(M_ABS);
        chk_tim(4'h6, 3'h3);
        aw = 1'b1;
        req(M_DIR);
        chk_tim(4'h7, 3'h2);
        rmw = 1'b0;
        req(M_IMM);
        chk_tim(4'h3, 3'h3);
        aw = 1'b0;
        xr = 16'h00FF;
        lo = 8'h01;
        req(M_ABS_X);
        chk_tim(4'h5, 3'h3);
        xr = 16'h0000;
        en = 1'b0;
        @(negedge clk);
        mode = M_IMM;
        calc = 1'b1;
        @(negedge clk);
        // Enable low: results hold instead of taking the request
        chk_val({23'h0, valid}, 24'h000001);
        chk_tim(4'h5, 3'h3);
        calc = 1'b0;
        en = 1'b1;
        $display("test extras done");
    endtask : t_extras

    // =====================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        {en, calc, lop, cond, rmw, sa, vf, aw, iw, rd} = 10'h200;
        mode = M_IMPL;
        {lo, hi, bk, data_bank_reg} = 32'h0000_0012;
        program_bank_reg = 8'h3C;
        {vec, pc, sp, xr, yr, dr} = 96'h0;
        scyc = 4'h3;
        slen = 3'h1;
        err_total = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_relative();
        t_stack();
        t_stack_ind();
        t_table();
        t_extras();
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge clk);
        hang("run");
    end
endmodule : addr_mode_eff_addr_timing_tb
`default_nettype wire
